// ===== src/sacr_convert_port.sv
// conversion control and parallel readout port of the sampling converter
`timescale 1ns/100ps
module sacr_convert_port
	import sacr_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYC_DEF
)
(
	input wire logic clk,
	input wire logic rst,
	input wire sacr_pkg::sacr_ctl_s ctlIn,
	input wire logic [15:0] sampleIn,
	output logic busyN_ff,
	output sacr_pkg::sacr_bus_s busOut_ff
);
	import sacr_pkg::*;

	// elaboration check: the 13-bit counter serves 1 to 4096 cycles
	if (CONV_CYC < 1 || CONV_CYC > 4096)
	begin : g_bad_cyc
		$error("CONV_CYC out of range");
	end

	// ***********************************************************
	// pin synchronisation
	// ***********************************************************
	logic [2:0] ctlSync;
	logic csN, rcN, byteSel;

	sacr_sync #(.W(3)) u_sync (
		.clk(clk),
		.rst(rst),
		.asyncIn({ctlIn.chipSelN, ctlIn.readConvN, ctlIn.byteSel}),
		.syncOut(ctlSync)
	);

	assign csN = ctlSync[2];
	assign rcN = ctlSync[1];
	assign byteSel = ctlSync[0];

	// ***********************************************************
	// trigger detection
	// ***********************************************************
	logic trigN, trigN_ff, startReq;

	assign trigN = csN | rcN;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			trigN_ff <= 1'b1;
		else
			trigN_ff <= trigN;
	end

	// falling edge of the ORed trigger covers both cs and strobe edges
	assign startReq = trigN_ff & ~trigN;

	// ***********************************************************
	// conversion sequencer
	// ***********************************************************
	sacr_state_e state_ff, nxt_state;
	logic [12:0] cnt_ff;
	logic [15:0] hold_ff, result_ff;

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			SACR_IDLE:
				if (startReq)
					nxt_state = SACR_CONV;
			SACR_CONV:
				if (cnt_ff == 13'(CONV_CYC - 1))
					nxt_state = SACR_DONE;
			SACR_DONE:
				nxt_state = SACR_IDLE;
			default:
				nxt_state = SACR_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_ff <= SACR_IDLE;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cnt_ff <= 13'h0000;
		else if (state_ff == SACR_CONV)
			cnt_ff <= cnt_ff + 13'h0001;
		else
			cnt_ff <= 13'h0000;
	end

	// sample goes into hold at the start; result updated at completion
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			hold_ff <= RES_RST;
			result_ff <= RES_RST;
		end
		else
		begin
			if (state_ff == SACR_IDLE && startReq)
				hold_ff <= sampleIn;
			if (state_ff == SACR_CONV && nxt_state == SACR_DONE)
				result_ff <= hold_ff;
		end
	end

	// busy falls with the start and rises one edge after the result is in
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			busyN_ff <= 1'b1;
		else
			busyN_ff <= (nxt_state == SACR_IDLE);
	end

	// ***********************************************************
	// parallel output
	// ***********************************************************
	logic drive;
	logic [15:0] laneData;

	assign drive = ~csN & rcN;

	// select low: whole word, msb on bit 15, upper half on the byte lane
	// select high: halves swapped so the lower half reaches the byte lane
	always_comb
	begin
		laneData = result_ff;
		if (byteSel)
			laneData = {result_ff[BYTE_W-1:0], result_ff[TOP_BIT -: BYTE_W]};
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			busOut_ff.data <= 16'h0000;
			busOut_ff.dataOeN <= 16'hffff;
		end
		else
		begin
			busOut_ff.data <= laneData;
			busOut_ff.dataOeN <= drive ? 16'h0000 : 16'hffff;
		end
	end

	// ***********************************************************
	// checks
	// ***********************************************************
	busy_on_start_a: assert property (@(posedge clk) disable iff (rst)
		(state_ff == SACR_IDLE && startReq) |=> !busyN_ff)
		else $error("busy not low after start");

	busy_hold_a: assert property (@(posedge clk) disable iff (rst)
		$fell(busyN_ff) |-> !busyN_ff [*2])
		else $error("busy rose too early");

	result_before_busy_a: assert property (@(posedge clk) disable iff (rst)
		$rose(busyN_ff) |-> $past(state_ff) == SACR_DONE)
		else $error("busy rose before result update");

	float_when_idle_a: assert property (@(posedge clk) disable iff (rst)
		(csN | ~rcN) |=> busOut_ff.dataOeN == 16'hffff)
		else $error("bus driven while deselected");

	drive_enable_a: assert property (@(posedge clk) disable iff (rst)
		(~csN & rcN) |=> busOut_ff.dataOeN == 16'h0000)
		else $error("bus not driven on read");

	top_byte_a: assert property (@(posedge clk) disable iff (rst)
		!byteSel |=> busOut_ff.data[15:8] == $past(result_ff[15:8]))
		else $error("upper byte wrong");

	low_byte_a: assert property (@(posedge clk) disable iff (rst)
		byteSel |=> busOut_ff.data[15:8] == $past(result_ff[7:0]))
		else $error("lower byte wrong");

	word_order_a: assert property (@(posedge clk) disable iff (rst)
		!byteSel |=> busOut_ff.data == $past(result_ff))
		else $error("word bit order wrong");

	trig_or_a: assert property (@(posedge clk) disable iff (rst)
		startReq |-> (!csN && !rcN))
		else $error("start without both low");

	no_start_busy_a: assert property (@(posedge clk) disable iff (rst)
		(state_ff == SACR_CONV) |=> state_ff != SACR_IDLE)
		else $error("conversion aborted");

	busy_ignore_a: assert property (@(posedge clk) disable iff (rst)
		(startReq && !busyN_ff) |=> $stable(hold_ff))
		else $error("start taken while busy");

	// helper: cycles that busy has been low, for the length check
	logic [12:0] busyLen_ff;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			busyLen_ff <= 13'h0000;
		else if (!busyN_ff)
			busyLen_ff <= busyLen_ff + 13'h0001;
		else
			busyLen_ff <= 13'h0000;
	end

	busy_length_a: assert property (@(posedge clk) disable iff (rst)
		$rose(busyN_ff) |-> $past(busyLen_ff) == 13'(CONV_CYC))
		else $error("busy length wrong");

endmodule : sacr_convert_port

// ===== src/sacr_pkg.sv
// package: constants and carrier types for the converter readout port
package sacr_pkg;

	// ***********************************************************
	// timing
	// ***********************************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int START_MIN_NS = 40;
	localparam int START_MIN_CYC = (START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
		(START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_CYC_DEF = 32;

	// ***********************************************************
	// data layout
	// ***********************************************************
	localparam int RES_W = 16;
	localparam int BYTE_W = 8;
	localparam int TOP_BIT = 15;
	localparam logic [15:0] RES_RST = 16'h0000;

	// ***********************************************************
	// types
	// ***********************************************************
	typedef struct packed
	{
		logic chipSelN;
		logic readConvN;
		logic byteSel;
	} sacr_ctl_s;

	typedef struct packed
	{
		logic [15:0] data;
		logic [15:0] dataOeN;
	} sacr_bus_s;

	typedef enum logic [1:0]
	{
		SACR_IDLE = 2'b00,
		SACR_CONV = 2'b01,
		SACR_DONE = 2'b11
	} sacr_state_e;

endpackage : sacr_pkg

// ===== src/sacr_sync.sv
// two-stage synchroniser for the host control pins
`timescale 1ns/100ps
module sacr_sync #(
	parameter int W = 3
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_ff <= '1;
			syncOut <= '1;
		end
		else
		begin
			meta_ff <= asyncIn;
			syncOut <= meta_ff;
		end
	end
endmodule : sacr_sync

// ===== verification/sacr_convert_port_test.sv
// self-checking bench for the converter readout port
`timescale 1ns/100ps
module sacr_convert_port_test;
	import sacr_pkg::*;
	localparam logic [15:0] CORNER [4] = '{16'h7fff, 16'h8000, 16'hffff,
		16'h0001};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] sampleIn = 16'h0000;
	logic busyN;
	sacr_bus_s bus;
	sacr_ctl_s ctl;
	logic [15:0] prev = 16'h0000;
	logic [15:0] cur;
	int err_total = 0;
	int samples_checked = 0;
	int seed = 32'hde041f98;

	always #50 clk = ~clk;

	sacr_convert_port #(.CONV_CYC(16)) sacr_convert_port_inst
	(
		.clk(clk),
		.rst(rst),
		.ctlIn(ctl),
		.sampleIn(sampleIn),
		.busyN_ff(busyN),
		.busOut_ff(bus)
	);

	sacr_host sacr_host_inst
	(
		.clk(clk),
		.ctlOut(ctl)
	);

	// select low: whole word; select high: lower half on the top lane
	function automatic logic [15:0] lane(logic [15:0] r, logic b);
		return b ? {r[7:0], r[15:8]} : r;
	endfunction : lane

	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		samples_checked++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic give_verdict();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	task automatic conv(logic [15:0] s, logic csLast);
		int n;
		n = 0;
		@(posedge clk);
		sampleIn <= s;
		if (csLast)
			sacr_host_inst.drive(1'b1, 1'b0, 1'b0, 2);
		sacr_host_inst.drive(1'b0, 1'b0, 1'b0, 5);
		chk("busyN", 16'h0000, {15'h0, busyN});
		chk("oeN", 16'hffff, bus.dataOeN);
		@(posedge clk);
		sampleIn <= ~s;
		// read during the conversion, then a start that must be ignored
		sacr_host_inst.drive(1'b0, 1'b1, 1'b0, 4);
		chk("oeN", 16'h0000, bus.dataOeN);
		chk("early", lane(prev, 1'b0), bus.data);
		chk("busyN", 16'h0000, {15'h0, busyN});
		sacr_host_inst.drive(1'b0, 1'b0, 1'b0, 2);
		sacr_host_inst.drive(1'b1, 1'b1, 1'b0, 1);
		while (busyN !== 1'b1 && n < 60)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("busyN", 16'h0001, {15'h0, busyN});
		chk("oeN", 16'hffff, bus.dataOeN);
		for (int b = 0; b < 2; b++)
		begin
			sacr_host_inst.drive(1'b0, 1'b1, b[0], 4);
			chk("data", lane(s, b[0]), bus.data);
			chk("busyN", 16'h0001, {15'h0, busyN});
		end
		prev = s;
	endtask : conv

	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk("busyN", 16'h0001, {15'h0, busyN});
		chk("oeN", 16'hffff, bus.dataOeN);
		for (int i = 0; i < 12; i++)
		begin
			cur = 16'($random(seed));
			if (i < 4)
				cur = CORNER[i];
			conv(cur, i[0]);
		end
		give_verdict();
	end

	initial
	begin
		repeat (2000) @(posedge clk);
		err_total++;
		give_verdict();
	end

endmodule : sacr_convert_port_test

// ===== verification/sacr_host.sv
// host model driving the converter control pins
`timescale 1ns/100ps
module sacr_host
	import sacr_pkg::*;
(
	input wire logic clk,
	output sacr_pkg::sacr_ctl_s ctlOut
);
	initial ctlOut = '{1'b1, 1'b1, 1'b0};

	// pins change after an edge and hold n cycles; starts use n>=2
	task automatic drive(logic cs, logic rc, logic b, int n);
		@(posedge clk);
		ctlOut <= '{cs, rc, b};
		repeat (n) @(posedge clk);
		#1;
	endtask : drive

endmodule : sacr_host
